// *** design/tic_pkg.sv ***
package tic_pkg;

    // register byte addresses
    localparam logic [23:0] TIC_ADDR_CONTROL  = 24'hFFFF10;
    localparam logic [23:0] TIC_ADDR_MODE     = 24'hFFFF11;
    localparam logic [23:0] TIC_ADDR_IOCTL_H  = 24'hFFFF12;
    localparam logic [23:0] TIC_ADDR_IOCTL_L  = 24'hFFFF13;
    localparam logic [23:0] TIC_ADDR_INT_EN   = 24'hFFFF14;
    localparam logic [23:0] TIC_ADDR_STATUS   = 24'hFFFF15;
    localparam logic [23:0] TIC_ADDR_COUNTER  = 24'hFFFF16;
    localparam logic [23:0] TIC_ADDR_GEN_A    = 24'hFFFF18;
    localparam logic [23:0] TIC_ADDR_GEN_B    = 24'hFFFF1A;
    localparam logic [23:0] TIC_ADDR_GEN_C    = 24'hFFFF1C;
    localparam logic [23:0] TIC_ADDR_GEN_D    = 24'hFFFF1E;
    localparam logic [23:0] TIC_ADDR_START    = 24'hFFFEB0;
    localparam logic [23:0] TIC_ADDR_SYNC     = 24'hFFFEB1;

    // field positions
    localparam int TIC_CCLR_LSB  = 5;
    localparam int TIC_CKEG_LSB  = 3;
    localparam int TIC_TPSC_LSB  = 0;
    localparam int TIC_BFB_BIT   = 5;
    localparam int TIC_BFA_BIT   = 4;
    localparam int TIC_IOB_LSB   = 4;
    localparam int TIC_IOA_LSB   = 0;
    localparam int TIC_ST_GFA    = 0;
    localparam int TIC_ST_GFB    = 1;
    localparam int TIC_ST_GFC    = 2;
    localparam int TIC_ST_GFD    = 3;
    localparam int TIC_ST_OVF    = 4;
    localparam int TIC_ST_DIR    = 7;

    // field codes
    localparam logic [2:0] TIC_CCLR_GEN_A  = 3'h1;
    localparam logic [2:0] TIC_CCLR_GEN_B  = 3'h2;
    localparam logic [2:0] TIC_TPSC_DIV1   = 3'h0;
    localparam logic [2:0] TIC_TPSC_DIV4   = 3'h1;
    localparam logic [2:0] TIC_TPSC_DIV16  = 3'h2;
    localparam logic [2:0] TIC_TPSC_DIV64  = 3'h3;
    localparam logic [3:0] TIC_IO_OFF      = 4'h0;
    localparam logic [3:0] TIC_IO_CAP_RISE = 4'h8;
    localparam logic [3:0] TIC_IO_CAP_FALL = 4'h9;
    localparam logic [3:0] TIC_MD_NORMAL   = 4'h0;

    // reset values and write masks
    localparam logic [7:0]  TIC_RST_BYTE   = 8'h00;
    localparam logic [7:0]  TIC_RST_STATUS = 8'h80;
    localparam logic [15:0] TIC_RST_WORD   = 16'h0000;
    localparam logic [7:0]  TIC_STATUS_W1C = 8'h1F;
    localparam logic [7:0]  TIC_INTEN_MASK = 8'h1F;

    // register port bundle
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tic_bus_req_t;

endpackage

// *** design/tic_capture_channel.sv ***
//Contract
//- each selected edge on capture pin A copies the running counter into register A; the code ignores pin A edges while the channel's run bit is clear
//- 16-bit readable writable up-counter, whole 16-bit accesses only
//- four 16-bit general registers A to D, whole-word access, compare or capture
//- start register holds one run bit each for channels 0 to 2
//- sync register selects independent or lockstep counting per channel
//- clear field 001 clears counter on register A match or capture
//- edge field 00 rising, 01 falling, 1X both edges of count clock
//- prescaler field 001 counts system clock divided by four
//- mode bit 5 pairs registers B and D as buffer
//- mode bit 4 pairs registers A and C as buffer
//- mode field 0000 selects normal operation
//- pin B field 0000 disables output on pin B
//- pin A field 1000 captures register A on rising pin edges
//- status register flags overflow and each register's capture or match
//- interrupt enable register gates each status flag's request
//- register A event sets status bit 0
//- counter overflow sets status bit 4, clear until an overflow
//
// Strobed register access was left to the implementer.
module tic_capture_channel
    import tic_pkg::*;
#(
    parameter int CH_INDEX = 0
) (
    // clock and reset
    input  wire logic        I_REF_CLK,
    input  wire logic        I_NRST,
    // register port
    input  wire logic [23:0] I_ADDR,
    input  wire logic [15:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [15:0] O_RDATA,
    // pins
    input  wire logic        I_CAPTURE_PIN_A,
    input  wire logic        I_CAPTURE_PIN_B,
    output logic             O_PIN_B_OUT,
    output logic             O_PIN_B_OE_N,
    output logic             O_START_OTHERS,
    output logic             O_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // channel index must name one of the three run bits
    if (CH_INDEX < 0 || CH_INDEX > 2) begin : g_ch_range
        $error("channel index out of range");
    end

    tic_bus_req_t bus;
    assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

    logic [7:0]  control_r, mode_r, ioctl_h_r, ioctl_l_r, int_en_r, status_r;
    logic [7:0]  start_r, sync_r;
    logic [15:0] counter_r, gen_r [4];
    logic [1:0]  pre_r;
    logic        pin_a_s1_r, pin_a_s2_r, pin_a_d_r;
    logic        pin_b_s1_r, pin_b_s2_r, pin_b_d_r;
    logic        tick_d_r;
    logic        pin_b_out_r;

    function automatic logic edge_hit(input logic [3:0] io, input logic now, input logic was);
        edge_hit = (io == TIC_IO_CAP_RISE && now && !was) ||
                   (io == TIC_IO_CAP_FALL && !now && was);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write decode
    function automatic logic wr_hit(input tic_bus_req_t b, input logic [23:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pin_a_s1_r <= 1'b0;
            pin_a_s2_r <= 1'b0;
            pin_a_d_r  <= 1'b0;
            pin_b_s1_r <= 1'b0;
            pin_b_s2_r <= 1'b0;
            pin_b_d_r  <= 1'b0;
        end else begin
            pin_a_s1_r <= I_CAPTURE_PIN_A;
            pin_a_s2_r <= pin_a_s1_r;
            pin_a_d_r  <= pin_a_s2_r;
            pin_b_s1_r <= I_CAPTURE_PIN_B;
            pin_b_s2_r <= pin_b_s1_r;
            pin_b_d_r  <= pin_b_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count clock: prescaler and edge selection
    logic       running;
    logic [2:0] tpsc;
    logic [1:0] ckeg;
    logic       tick_lvl;
    logic       count_en;

    assign running  = start_r[CH_INDEX];
    assign tpsc     = control_r[TIC_TPSC_LSB +: 3];
    assign ckeg     = control_r[TIC_CKEG_LSB +: 2];

    always_comb begin
        case (tpsc)
            TIC_TPSC_DIV4:  tick_lvl = pre_r[1];
            TIC_TPSC_DIV16: tick_lvl = pre_r[1];
            default:        tick_lvl = pre_r[0];
        endcase
    end

    always_comb begin
        if (tpsc == TIC_TPSC_DIV1) begin
            count_en = running;
        end else if (ckeg[1]) begin
            count_en = running && (tick_lvl != tick_d_r);
        end else if (ckeg[0]) begin
            count_en = running && !tick_lvl && tick_d_r;
        end else begin
            count_en = running && tick_lvl && !tick_d_r;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pre_r    <= 2'h0;
            tick_d_r <= 1'b0;
        end else begin
            pre_r    <= pre_r + 2'h1;
            tick_d_r <= tick_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events
    logic cap_a, cap_b, match_a, match_b, match_c, match_d, ovf, clr_cnt;
    logic [3:0] io_a, io_b;

    assign io_a    = ioctl_h_r[TIC_IOA_LSB +: 4];
    assign io_b    = ioctl_h_r[TIC_IOB_LSB +: 4];
    assign cap_a   = running && edge_hit(io_a, pin_a_s2_r, pin_a_d_r);
    assign cap_b   = running && edge_hit(io_b, pin_b_s2_r, pin_b_d_r);
    assign match_a = count_en && !io_a[3] && counter_r == gen_r[0];
    assign match_b = count_en && !io_b[3] && counter_r == gen_r[1];
    assign match_c = count_en && counter_r == gen_r[2];
    assign match_d = count_en && counter_r == gen_r[3];
    assign ovf     = count_en && counter_r == 16'hFFFF;
    assign clr_cnt = (control_r[TIC_CCLR_LSB +: 3] == TIC_CCLR_GEN_A
                      && (cap_a || match_a))
                  || (control_r[TIC_CCLR_LSB +: 3] == TIC_CCLR_GEN_B
                      && (cap_b || match_b));

    ////////////////////////////////////////////////////////////////////////
    // counter
    logic wr_cnt;
    assign wr_cnt = wr_hit(bus, TIC_ADDR_COUNTER);

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            counter_r <= TIC_RST_WORD;
        end else if (wr_cnt) begin
            counter_r <= bus.wdata;
        end else if (clr_cnt && mode_r[3:0] == TIC_MD_NORMAL) begin
            counter_r <= TIC_RST_WORD;
        end else if (clr_cnt) begin
            counter_r <= TIC_RST_WORD;
        end else if (count_en) begin
            counter_r <= counter_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general registers with buffer pairing
    logic [23:0] gen_addr [4];
    assign gen_addr[0] = TIC_ADDR_GEN_A;
    assign gen_addr[1] = TIC_ADDR_GEN_B;
    assign gen_addr[2] = TIC_ADDR_GEN_C;
    assign gen_addr[3] = TIC_ADDR_GEN_D;

    logic buf_a, buf_b;
    assign buf_a = mode_r[TIC_BFA_BIT];
    assign buf_b = mode_r[TIC_BFB_BIT];

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            gen_r[0] <= TIC_RST_WORD;
            gen_r[2] <= TIC_RST_WORD;
        end else begin
            if (wr_hit(bus, gen_addr[0])) begin
                gen_r[0] <= bus.wdata;
            end else if (cap_a) begin
                gen_r[0] <= counter_r;
            end else if (buf_a && match_a) begin
                gen_r[0] <= gen_r[2];
            end
            if (wr_hit(bus, gen_addr[2])) begin
                gen_r[2] <= bus.wdata;
            end else if (buf_a && cap_a) begin
                gen_r[2] <= gen_r[0];
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            gen_r[1] <= TIC_RST_WORD;
            gen_r[3] <= TIC_RST_WORD;
        end else begin
            if (wr_hit(bus, gen_addr[1])) begin
                gen_r[1] <= bus.wdata;
            end else if (cap_b) begin
                gen_r[1] <= counter_r;
            end else if (buf_b && match_b) begin
                gen_r[1] <= gen_r[3];
            end
            if (wr_hit(bus, gen_addr[3])) begin
                gen_r[3] <= bus.wdata;
            end else if (buf_b && cap_b) begin
                gen_r[3] <= gen_r[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            control_r <= TIC_RST_BYTE;
            mode_r    <= TIC_RST_BYTE;
            ioctl_h_r <= TIC_RST_BYTE;
            ioctl_l_r <= TIC_RST_BYTE;
            int_en_r  <= TIC_RST_BYTE;
            start_r   <= TIC_RST_BYTE;
            sync_r    <= TIC_RST_BYTE;
        end else if (bus.wr) begin
            if (bus.addr == TIC_ADDR_CONTROL) begin
                control_r <= bus.wdata[7:0];
            end else if (bus.addr == TIC_ADDR_MODE) begin
                mode_r <= {2'h0, bus.wdata[5:4], 1'b0, bus.wdata[2:0]};
            end else if (bus.addr == TIC_ADDR_IOCTL_H) begin
                ioctl_h_r <= bus.wdata[7:0];
            end else if (bus.addr == TIC_ADDR_IOCTL_L) begin
                ioctl_l_r <= bus.wdata[7:0];
            end else if (bus.addr == TIC_ADDR_INT_EN) begin
                int_en_r <= bus.wdata[7:0] & TIC_INTEN_MASK;
            end else if (bus.addr == TIC_ADDR_START) begin
                start_r <= {5'h00, bus.wdata[2:0]};
            end else if (bus.addr == TIC_ADDR_SYNC) begin
                sync_r <= {5'h00, bus.wdata[2:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags, set wins over clear
    logic [7:0] ev;
    logic [7:0] clr_mask;
    assign ev = {3'h0, ovf, cap_b || match_d, match_c, cap_b || match_b,
                 cap_a || match_a};
    assign clr_mask = wr_hit(bus, TIC_ADDR_STATUS)
                      ? (bus.wdata[7:0] & TIC_STATUS_W1C) : 8'h00;

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            status_r <= TIC_RST_STATUS;
        end else begin
            status_r <= (status_r & ~clr_mask) | ev;
        end
    end

    assign O_IRQ = |(status_r & int_en_r & TIC_INTEN_MASK);

    // lockstep: a synchronised channel mirrors its run bit to the others
    assign O_START_OTHERS = sync_r[CH_INDEX] && running;

    ////////////////////////////////////////////////////////////////////////
    // pin B output: off for code 0000 or capture codes
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pin_b_out_r <= 1'b0;
        end else if (io_b == TIC_IO_OFF || io_b[3]) begin
            pin_b_out_r <= 1'b0;
        end else if (match_b) begin
            case (io_b[1:0])
                2'h1:    pin_b_out_r <= 1'b0;
                2'h2:    pin_b_out_r <= 1'b1;
                2'h3:    pin_b_out_r <= ~pin_b_out_r;
                default: pin_b_out_r <= pin_b_out_r;
            endcase
        end
    end

    assign O_PIN_B_OUT  = pin_b_out_r;
    assign O_PIN_B_OE_N = (io_b == TIC_IO_OFF) || io_b[3];

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    logic [15:0] rd_nxt;
    always_comb begin
        if (bus.addr == TIC_ADDR_CONTROL) begin
            rd_nxt = {8'h00, control_r};
        end else if (bus.addr == TIC_ADDR_MODE) begin
            rd_nxt = {8'h00, mode_r | 8'hC0};
        end else if (bus.addr == TIC_ADDR_IOCTL_H) begin
            rd_nxt = {8'h00, ioctl_h_r};
        end else if (bus.addr == TIC_ADDR_IOCTL_L) begin
            rd_nxt = {8'h00, ioctl_l_r};
        end else if (bus.addr == TIC_ADDR_INT_EN) begin
            rd_nxt = {8'h00, int_en_r};
        end else if (bus.addr == TIC_ADDR_STATUS) begin
            rd_nxt = {8'h00, status_r};
        end else if (bus.addr == TIC_ADDR_COUNTER) begin
            rd_nxt = counter_r;
        end else if (bus.addr == gen_addr[0]) begin
            rd_nxt = gen_r[0];
        end else if (bus.addr == gen_addr[1]) begin
            rd_nxt = gen_r[1];
        end else if (bus.addr == gen_addr[2]) begin
            rd_nxt = gen_r[2];
        end else if (bus.addr == gen_addr[3]) begin
            rd_nxt = gen_r[3];
        end else if (bus.addr == TIC_ADDR_START) begin
            rd_nxt = {8'h00, start_r};
        end else if (bus.addr == TIC_ADDR_SYNC) begin
            rd_nxt = {8'h00, sync_r};
        end else begin
            rd_nxt = 16'h0000;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RDATA <= 16'h0000;
        end else if (bus.rd) begin
            O_RDATA <= rd_nxt;
        end else begin
            O_RDATA <= 16'h0000;
        end
    end

endmodule

// *** tb/tic_pulse_src.sv ***
module tic_pulse_src (
    // clock
    input  wire logic i_clk,
    // capture pin drive
    output logic      o_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial o_pin = 1'b0;

    // one pulse, both phases at least two clocks
    task automatic pulse(input int hi, input int lo);
        @(posedge i_clk);
        o_pin <= 1'b1;
        repeat (hi) @(posedge i_clk);
        o_pin <= 1'b0;
        repeat (lo) @(posedge i_clk);
    endtask
endmodule

// *** tb/tic_capture_monitor.sv ***
module tic_capture_monitor
    import tic_pkg::*;
(
    input wire logic        I_REF_CLK,
    input wire logic        I_NRST,
    input wire logic [23:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [15:0] O_RDATA,
    input wire logic        I_CAPTURE_PIN_A,
    input wire logic        I_CAPTURE_PIN_B,
    input wire logic        O_PIN_B_OUT,
    input wire logic        O_PIN_B_OE_N,
    input wire logic        O_START_OTHERS,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_NRST);

    rd_idle_a: assert property (!I_RD |=> O_RDATA == 16'h0000)
        else $error("read data not zero outside read slot");
    unmapped_read_a: assert property ((I_RD && I_ADDR[23:8] == 16'h0000) |=> O_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    status_dir_a: assert property ((I_RD && I_ADDR == TIC_ADDR_STATUS) |=> (O_RDATA[15:7] == 9'h001))
        else $error("status upper bits wrong");
    mode_fixed_a: assert property ((I_RD && I_ADDR == TIC_ADDR_MODE) |=> (O_RDATA[15:6] == 10'h003 && !O_RDATA[3]))
        else $error("mode fixed bits wrong");
    pin_b_off_a: assert property ((I_WR && I_ADDR == TIC_ADDR_IOCTL_H && I_WDATA[7:4] == 4'h0)
        |=> ##1 (O_PIN_B_OE_N && !O_PIN_B_OUT))
        else $error("pin b driven while disabled");
    start_off_a: assert property ((I_WR && I_ADDR == TIC_ADDR_START && !I_WDATA[0]) |=> !O_START_OTHERS)
        else $error("sync start high while stopped");
    irq_mask_a: assert property ((I_WR && I_ADDR == TIC_ADDR_INT_EN && I_WDATA[4:0] == 5'h00) |=> !O_IRQ)
        else $error("interrupt high with all enables off");
    word_back_a: assert property ((I_WR && I_ADDR == TIC_ADDR_GEN_B) ##1 (I_RD && I_ADDR == TIC_ADDR_GEN_B)
        |=> O_RDATA == $past(I_WDATA, 2))
        else $error("register b readback wrong");
endmodule

bind tic_capture_channel tic_capture_monitor tic_capture_monitor_i (
    .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CAPTURE_PIN_A(I_CAPTURE_PIN_A),
    .I_CAPTURE_PIN_B(I_CAPTURE_PIN_B), .O_PIN_B_OUT(O_PIN_B_OUT),
    .O_PIN_B_OE_N(O_PIN_B_OE_N), .O_START_OTHERS(O_START_OTHERS), .O_IRQ(O_IRQ)
);

// *** tb/tb_timer_input_capture_channel.sv ***
`define CHK(nm, exp, got) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
end

module tb_timer_input_capture_channel;
    import tic_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk, nrst, wr_en, rd_en, pin_a, pin_b_out, pin_b_oe_n, start_others, irq;
    logic [23:0] addr;
    logic [15:0] wdata, rdata, v;
    int          bad_count = 0;
    int          n_checks = 0;

    tic_capture_channel tic_capture_channel_i (
        .I_REF_CLK(ref_clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_en),
        .I_RD(rd_en), .O_RDATA(rdata), .I_CAPTURE_PIN_A(pin_a), .I_CAPTURE_PIN_B(1'b0),
        .O_PIN_B_OUT(pin_b_out), .O_PIN_B_OE_N(pin_b_oe_n), .O_START_OTHERS(start_others),
        .O_IRQ(irq)
    );
    tic_pulse_src tic_pulse_src_i (.i_clk(ref_clk), .o_pin(pin_a));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus_wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [23:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wr_rd(input logic [23:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 `CHK("word", d, rdata)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus_rd(TIC_ADDR_STATUS, v);
        `CHK("status", 16'h0080, v)
        bus_rd(TIC_ADDR_COUNTER, v);
        `CHK("counter", 16'h0000, v)
        `CHK("irq", 1'b0, irq)
        `CHK("pin_b_out", 1'b0, pin_b_out)
        `CHK("oe_n", 1'b1, pin_b_oe_n)
    endtask

    task automatic t_regs();
        logic [23:0] a [5] = '{TIC_ADDR_COUNTER, TIC_ADDR_GEN_A, TIC_ADDR_GEN_B,
                                TIC_ADDR_GEN_C, TIC_ADDR_GEN_D};
        for (int i = 0; i < 5; i++) begin
            wr_rd(a[i], 16'hFFFF);
            wr_rd(a[i], 16'h5AA5 ^ 16'(i));
        end
        bus_wr(24'h000010, 16'hFFFF);
        bus_rd(24'h000010, v);
        `CHK("unmapped", 16'h0000, v)
        bus_wr(TIC_ADDR_MODE, 16'h0000);
        bus_rd(TIC_ADDR_MODE, v);
        `CHK("mode", 16'h00C0, v)
    endtask

    task automatic t_capture();
        bus_wr(TIC_ADDR_CONTROL, 16'h0021);
        bus_wr(TIC_ADDR_IOCTL_H, 16'h0008);
        bus_wr(TIC_ADDR_INT_EN, 16'h0001);
        bus_wr(TIC_ADDR_START, 16'h0001);
        tic_pulse_src_i.pulse(100, 100);
        tic_pulse_src_i.pulse(100, 100);
        bus_rd(TIC_ADDR_GEN_A, v);
        `CHK("period", 1'b1, (v >= 16'd48 && v <= 16'd52))
        bus_rd(TIC_ADDR_STATUS, v);
        `CHK("flag_a", 1'b1, v[0])
        `CHK("irq_on", 1'b1, irq)
        `CHK("oe_n", 1'b1, pin_b_oe_n)
        bus_wr(TIC_ADDR_INT_EN, 16'h0000);
        `CHK("irq_mask", 1'b0, irq)
        bus_wr(TIC_ADDR_INT_EN, 16'h0001);
        `CHK("irq_unmask", 1'b1, irq)
        bus_wr(TIC_ADDR_STATUS, 16'h0001);
        `CHK("irq_clr", 1'b0, irq)
    endtask

    task automatic t_hold();
        logic [15:0] a0;
        bus_wr(TIC_ADDR_SYNC, 16'h0001);
        `CHK("sync_on", 1'b1, start_others)
        bus_wr(TIC_ADDR_START, 16'h0000);
        `CHK("sync_off", 1'b0, start_others)
        bus_rd(TIC_ADDR_GEN_A, a0);
        tic_pulse_src_i.pulse(10, 10);
        bus_rd(TIC_ADDR_GEN_A, v);
        `CHK("hold_a", a0, v)
        bus_rd(TIC_ADDR_STATUS, v);
        `CHK("no_flag", 1'b0, v[0])
    endtask

    task automatic t_buffer();
        bus_wr(TIC_ADDR_MODE, 16'h0010);
        bus_wr(TIC_ADDR_GEN_A, 16'h1234);
        bus_wr(TIC_ADDR_START, 16'h0001);
        tic_pulse_src_i.pulse(10, 10);
        bus_rd(TIC_ADDR_GEN_C, v);
        `CHK("buf_c", 16'h1234, v)
        bus_wr(TIC_ADDR_MODE, 16'h0000);
    endtask

    task automatic t_ovf();
        bus_wr(TIC_ADDR_START, 16'h0000);
        bus_wr(TIC_ADDR_CONTROL, 16'h0000);
        bus_wr(TIC_ADDR_COUNTER, 16'hFFFE);
        bus_rd(TIC_ADDR_STATUS, v);
        `CHK("no_ovf", 1'b0, v[4])
        bus_wr(TIC_ADDR_START, 16'h0001);
        repeat (4) @(posedge ref_clk);
        bus_wr(TIC_ADDR_START, 16'h0000);
        bus_rd(TIC_ADDR_STATUS, v);
        `CHK("ovf", 1'b1, v[4])
        bus_rd(TIC_ADDR_COUNTER, v);
        `CHK("wrap", 16'h0004, v)
    endtask

    task automatic t_edge();
        bus_wr(TIC_ADDR_CONTROL, 16'h0019);
        bus_wr(TIC_ADDR_COUNTER, 16'h0000);
        bus_wr(TIC_ADDR_START, 16'h0001);
        repeat (40) @(posedge ref_clk);
        bus_wr(TIC_ADDR_START, 16'h0000);
        bus_rd(TIC_ADDR_COUNTER, v);
        `CHK("edge_both", 16'd21, v)
        bus_wr(TIC_ADDR_CONTROL, 16'h0009);
        bus_wr(TIC_ADDR_COUNTER, 16'h0000);
        bus_wr(TIC_ADDR_START, 16'h0001);
        repeat (40) @(posedge ref_clk);
        bus_wr(TIC_ADDR_START, 16'h0000);
        bus_rd(TIC_ADDR_COUNTER, v);
        `CHK("edge_fall", 1'b1, (v >= 16'd10 && v <= 16'd11))
    endtask

    task automatic t_buf_b();
        bus_wr(TIC_ADDR_CONTROL, 16'h0000);
        bus_wr(TIC_ADDR_MODE, 16'h0020);
        bus_wr(TIC_ADDR_GEN_D, 16'hBEEF);
        bus_wr(TIC_ADDR_GEN_B, 16'h0010);
        bus_wr(TIC_ADDR_COUNTER, 16'h000E);
        bus_wr(TIC_ADDR_STATUS, 16'h001F);
        bus_wr(TIC_ADDR_START, 16'h0001);
        repeat (4) @(posedge ref_clk);
        bus_wr(TIC_ADDR_START, 16'h0000);
        bus_rd(TIC_ADDR_GEN_B, v);
        `CHK("buf_b", 16'hBEEF, v)
        bus_rd(TIC_ADDR_STATUS, v);
        `CHK("flag_b", 1'b1, v[1])
        `CHK("pin_b_quiet", 1'b0, pin_b_out)
        bus_wr(TIC_ADDR_MODE, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        #1000000;
        bad_count++;
        print_verdict();
    end

    initial begin
        nrst = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 24'h000000;
        wdata = 16'h0000;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_capture();
        t_hold();
        t_buffer();
        t_ovf();
        t_edge();
        t_buf_b();
        print_verdict();
    end
endmodule
